// ### rtl/scr_pkg.sv
// Shared constants, register map and word-ordering function for the serial channel registers.
package scr_pkg;
    localparam int unsigned NCH = 2;
    localparam int unsigned NFLG = 4;
    localparam int unsigned NSYNC = 4;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned CNT_W = 5;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [4:0] CNT_LAST = 5'h1F;
    localparam logic [4:0] CNT_ONE = 5'h01;
    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_SWAP = 6'h0F;
    localparam logic [5:0] IDX_CHAN = 6'h10;
    localparam logic [5:0] IDX_ORDER = 6'h16;
    localparam logic [5:0] IDX_UNDER = 6'h18;
    localparam logic [5:0] IDX_OVER = 6'h1A;
    localparam logic [5:0] IDX_PLL = 6'h24;
    localparam logic [5:0] IDX_CMD = 6'h28;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h29;
    localparam logic [5:0] IDX_IRQ_EN = 6'h2A;
    localparam logic [5:0] IDX_IRQ_CLR = 6'h2B;
    // Field positions.
    localparam int unsigned SWAP_BYTE_BIT = 0;
    localparam int unsigned SWAP_SHORT_BIT = 3;
    localparam int unsigned PLL_ON_BIT = 2;
    localparam int unsigned PLL_LOCK_BIT = 5;
    localparam int unsigned CMD_EN_BIT = 0;
    localparam int unsigned FIRST_TX_FLAG = 2;
    localparam int unsigned SYNC_LCLK = 0;
    localparam int unsigned SYNC_RX = 1;
    localparam int unsigned SYNC_LOCK = 3;
    // Reset value shared by every register.
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h00000000;

    // Swaps and bit reversal commute and are each their own inverse, so the
    // same function orders a word for sending and restores a received one.
    function automatic logic [31:0] scr_order(input logic [31:0] w, input logic bs,
                                              input logic ss, input logic lsb);
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        a = ss ? {w[15:0], w[31:16]} : w;
        b = bs ? {a[23:16], a[31:24], a[7:0], a[15:8]} : a;
        for (int i = 0; i < 32; i++)
        begin
            c[i] = b[31-i];
        end
        return lsb ? c : b;
    endfunction
endpackage

// ### rtl/scr_tx_ser.sv
// One transmit channel: a one-word holding stage and a 32-bit serialiser.
module scr_tx_ser (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic chan_on,
    input wire logic lsb_first,
    input wire logic byte_swap,
    input wire logic short_swap,
    input wire logic bit_tick,
    input wire logic word_valid,
    input wire logic [scr_pkg::WORD_W-1:0] word_data,
    output logic word_ready,
    output logic sdata,
    output logic underflow
);
    import scr_pkg::*;
    logic [WORD_W-1:0] hold_q, shift_q, shift_d, ordered;
    logic [CNT_W-1:0] cnt_q;
    logic [7:0] last_q, last_d;
    logic full_q, full_d, started_q, take, load, unf_d;

    assign take = word_valid & word_ready & chan_on;
    assign load = bit_tick & (cnt_q == CNT_LAST);
    assign ordered = scr_order(hold_q, byte_swap, short_swap, lsb_first);
    assign unf_d = load & ~full_q & started_q;
    assign full_d = chan_on & (take | (full_q & ~load));

    always_comb
    begin
        shift_d = {shift_q[WORD_W-2:0], 1'b0};
        last_d = last_q;
        if (load & full_q)
        begin
            shift_d = ordered;
            last_d = ordered[7:0];
        end
        else if (load)
        begin
            // Nothing to send: keep repeating the byte that went out last.
            shift_d = {4{last_q}};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hold_q <= RST_WORD;
            shift_q <= RST_WORD;
            cnt_q <= RST_REG[CNT_W-1:0];
            last_q <= RST_REG;
            full_q <= 1'b0;
            started_q <= 1'b0;
            word_ready <= 1'b0;
            sdata <= 1'b0;
            underflow <= 1'b0;
        end
        else if (ce)
        begin
            full_q <= full_d;
            word_ready <= chan_on & ~full_d;
            underflow <= chan_on & unf_d;
            if (take)
                hold_q <= word_data;
            if (!chan_on)
            begin
                shift_q <= RST_WORD;
                cnt_q <= RST_REG[CNT_W-1:0];
                last_q <= RST_REG;
                started_q <= 1'b0;
                sdata <= 1'b0;
            end
            else
            begin
                started_q <= started_q | take;
                if (bit_tick)
                begin
                    sdata <= shift_q[WORD_W-1];
                    shift_q <= shift_d;
                    last_q <= last_d;
                    cnt_q <= cnt_q + CNT_ONE;
                end
            end
        end
    end
endmodule

// ### rtl/scr_rx_des.sv
// One receive channel: a 32-bit deserialiser and a one-word output stage.
module scr_rx_des (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic chan_on,
    input wire logic lsb_first,
    input wire logic byte_swap,
    input wire logic short_swap,
    input wire logic bit_tick,
    input wire logic sdata_in,
    input wire logic ovf_flag,
    input wire logic word_ready,
    output logic [scr_pkg::WORD_W-1:0] word_data,
    output logic word_valid,
    output logic overflow
);
    import scr_pkg::*;
    logic [WORD_W-1:0] shift_q, shift_d;
    logic [CNT_W-1:0] cnt_q;
    logic done, busy, drop;

    assign shift_d = {shift_q[WORD_W-2:0], sdata_in};
    assign done = chan_on & bit_tick & (cnt_q == CNT_LAST);
    assign busy = word_valid & ~word_ready;
    // A word that finds the stage full, or arrives while the flag stands, is dropped.
    assign drop = done & (busy | ovf_flag);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shift_q <= RST_WORD;
            cnt_q <= RST_REG[CNT_W-1:0];
            word_data <= RST_WORD;
            word_valid <= 1'b0;
            overflow <= 1'b0;
        end
        else if (ce)
        begin
            overflow <= done & busy;
            if (!chan_on)
            begin
                shift_q <= RST_WORD;
                cnt_q <= RST_REG[CNT_W-1:0];
                word_valid <= 1'b0;
            end
            else
            begin
                if (bit_tick)
                begin
                    shift_q <= shift_d;
                    cnt_q <= cnt_q + CNT_ONE;
                end
                if (done & ~drop)
                begin
                    word_data <= scr_order(shift_d, byte_swap, short_swap, lsb_first);
                    word_valid <= 1'b1;
                end
                else if (word_valid & word_ready)
                begin
                    word_valid <= 1'b0;
                end
            end
        end
    end
endmodule

// ### rtl/scr_regs_top.sv
// APB register bank, flag logic and channel serialisers of the serial video block.
//
// Functional notes
// - LSB-first bit set sends bit 0 first.
// - LSB-first bit clear sends MSB first.
// - Bit order combines with byte and short swap.
// - Underflow flags bits 3-0, sticky until re-enable; only bits 3-2 (tx) are ever set, and a command enable also clears them.
// - Underflowed transmitter repeats last valid byte.
// - Overflow flags bits 3-0, sticky until re-enable; only bits 1-0 (rx) are ever set, and a command enable also clears them.
// - Receive data discarded while in overflow.
// - Flags clear only on disable then enable; a command enable write to bit 0 also clears them.
// - PLL control bit 2 enables system PLL.
// - Bit 5 reads PLL lock status.
// - Bits 4-3,1-0 read back; 7-6 zero.
// - Flag bits map rx0, rx1, tx0, tx1.
module scr_regs_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [scr_pkg::ADDR_W-1:0] paddr,
    input wire logic [scr_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [scr_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_clk,
    input wire logic [scr_pkg::NCH-1:0] rx_sdata,
    output logic [scr_pkg::NCH-1:0] tx_sdata,
    input wire logic [scr_pkg::NCH-1:0] tx_valid,
    input wire logic [scr_pkg::NCH-1:0][scr_pkg::WORD_W-1:0] tx_word,
    output logic [scr_pkg::NCH-1:0] tx_ready,
    output logic [scr_pkg::NCH-1:0][scr_pkg::WORD_W-1:0] rx_word,
    output logic [scr_pkg::NCH-1:0] rx_valid,
    input wire logic [scr_pkg::NCH-1:0] rx_ready,
    input wire logic pll_lock,
    output logic pll_enable,
    output logic irq
);
    import scr_pkg::*;

    function automatic logic is_reg(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
        return (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'h0);
    endfunction

    // Register state.
    logic [1:0] swap_q;
    logic [NFLG-1:0] chan_q, chan_prev_q;
    logic [NCH-1:0] order_q;
    logic [4:0] pll_q;
    logic [7:0] irq_en_q, irq_stat_q, irq_stat_d;
    logic [NFLG-1:0] unf_q, unf_d, ovf_q, ovf_d;
    logic cmd_pulse_q;

    // Bus decode.
    logic access, ack_d, commit, wr;
    logic hit, wr_swap, wr_chan, wr_order, wr_pll, wr_cmd, wr_irq_en, wr_irq_clr;
    logic [7:0] wbyte;
    logic [DATA_W-1:0] rd_data;

    // Link side.
    logic [NSYNC-1:0] async_in, s1_q, s2_q;
    logic lclk_d_q, bit_tick, lock_s;
    logic [NCH-1:0] rx_s;
    logic [NCH-1:0] tx_unf, rx_ovf;
    logic [NFLG-1:0] unf_ev, ovf_ev, flag_clr;
    logic byte_swap, short_swap;

    // Read data is registered, so every access has one wait state.
    assign access = psel & penable;
    assign ack_d = access & ~pready;
    assign commit = access & pready;
    assign wr = commit & pwrite & pstrb[0];
    assign wbyte = pwdata[7:0];

    assign hit = is_reg(paddr, IDX_SWAP) | is_reg(paddr, IDX_CHAN) |
                 is_reg(paddr, IDX_ORDER) | is_reg(paddr, IDX_UNDER) |
                 is_reg(paddr, IDX_OVER) | is_reg(paddr, IDX_PLL) |
                 is_reg(paddr, IDX_CMD) | is_reg(paddr, IDX_IRQ_STAT) |
                 is_reg(paddr, IDX_IRQ_EN) | is_reg(paddr, IDX_IRQ_CLR);

    // Status registers have no write strobe at all, so writes there are lost.
    assign wr_swap = wr & is_reg(paddr, IDX_SWAP);
    assign wr_chan = wr & is_reg(paddr, IDX_CHAN);
    assign wr_order = wr & is_reg(paddr, IDX_ORDER);
    assign wr_pll = wr & is_reg(paddr, IDX_PLL);
    assign wr_cmd = wr & is_reg(paddr, IDX_CMD);
    assign wr_irq_en = wr & is_reg(paddr, IDX_IRQ_EN);
    assign wr_irq_clr = wr & is_reg(paddr, IDX_IRQ_CLR);

    always_comb
    begin
        rd_data = RST_WORD;
        if (is_reg(paddr, IDX_SWAP))
        begin
            rd_data[SWAP_BYTE_BIT] = swap_q[0];
            rd_data[SWAP_SHORT_BIT] = swap_q[1];
        end
        else if (is_reg(paddr, IDX_CHAN))
        begin
            rd_data[NFLG-1:0] = chan_q;
        end
        else if (is_reg(paddr, IDX_ORDER))
        begin
            rd_data[NCH-1:0] = order_q;
        end
        else if (is_reg(paddr, IDX_UNDER))
        begin
            rd_data[NFLG-1:0] = unf_q;
        end
        else if (is_reg(paddr, IDX_OVER))
        begin
            rd_data[NFLG-1:0] = ovf_q;
        end
        else if (is_reg(paddr, IDX_PLL))
        begin
            rd_data[4:0] = pll_q;
            rd_data[PLL_LOCK_BIT] = lock_s;
        end
        else if (is_reg(paddr, IDX_IRQ_STAT))
        begin
            rd_data[7:0] = irq_stat_q;
        end
        else if (is_reg(paddr, IDX_IRQ_EN))
        begin
            rd_data[7:0] = irq_en_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RST_WORD;
        end
        else if (ce)
        begin
            pready <= ack_d;
            pslverr <= ack_d & ~hit;
            prdata <= (ack_d & ~pwrite) ? rd_data : RST_WORD;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            swap_q <= RST_REG[1:0];
            chan_q <= RST_REG[NFLG-1:0];
            order_q <= RST_REG[NCH-1:0];
            pll_q <= RST_REG[4:0];
            irq_en_q <= RST_REG;
            cmd_pulse_q <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_swap)
                swap_q <= {wbyte[SWAP_SHORT_BIT], wbyte[SWAP_BYTE_BIT]};
            if (wr_chan)
                chan_q <= wbyte[NFLG-1:0];
            if (wr_order)
                order_q <= wbyte[NCH-1:0];
            if (wr_pll)
                pll_q <= wbyte[4:0];
            if (wr_irq_en)
                irq_en_q <= wbyte;
            cmd_pulse_q <= wr_cmd & wbyte[CMD_EN_BIT];
        end
    end

    assign pll_enable = pll_q[PLL_ON_BIT];

    // Two-flop synchronisers for the link clock, the receive lines and the lock pin.
    assign async_in = {pll_lock, rx_sdata, link_clk};

    genvar g;
    generate
        for (g = 0; g < NSYNC; g++)
        begin : g_sync
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    s1_q[g] <= 1'b0;
                    s2_q[g] <= 1'b0;
                end
                else if (ce)
                begin
                    s1_q[g] <= async_in[g];
                    s2_q[g] <= s1_q[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lclk_d_q <= 1'b0;
        else if (ce)
            lclk_d_q <= s2_q[SYNC_LCLK];
    end

    // The link clock must be well below pclk/2 or edges are missed.
    assign bit_tick = s2_q[SYNC_LCLK] & ~lclk_d_q;
    assign rx_s = s2_q[SYNC_RX+NCH-1:SYNC_RX];
    assign lock_s = s2_q[SYNC_LOCK];
    assign byte_swap = swap_q[0];
    assign short_swap = swap_q[1];

    generate
        for (g = 0; g < NCH; g++)
        begin : g_chan
            scr_rx_des u_rx (
                .pclk(pclk),
                .presetn(presetn),
                .ce(ce),
                .chan_on(chan_q[g]),
                .lsb_first(order_q[g]),
                .byte_swap(byte_swap),
                .short_swap(short_swap),
                .bit_tick(bit_tick),
                .sdata_in(rx_s[g]),
                .ovf_flag(ovf_q[g]),
                .word_ready(rx_ready[g]),
                .word_data(rx_word[g]),
                .word_valid(rx_valid[g]),
                .overflow(rx_ovf[g])
            );
            scr_tx_ser u_tx (
                .pclk(pclk),
                .presetn(presetn),
                .ce(ce),
                .chan_on(chan_q[FIRST_TX_FLAG+g]),
                .lsb_first(order_q[g]),
                .byte_swap(byte_swap),
                .short_swap(short_swap),
                .bit_tick(bit_tick),
                .word_valid(tx_valid[g]),
                .word_data(tx_word[g]),
                .word_ready(tx_ready[g]),
                .sdata(tx_sdata[g]),
                .underflow(tx_unf[g])
            );
        end
    endgenerate

    // Receive stages are drained by a handshake and never run dry; transmit
    // stages refuse words when full, so those flag bits stay clear.
    assign unf_ev = {tx_unf, 2'h0};
    assign ovf_ev = {2'h0, rx_ovf};

    // Clear on a 0-to-1 change of the channel enable or on a command enable.
    assign flag_clr = (chan_q & ~chan_prev_q) | {NFLG{cmd_pulse_q}};
    assign unf_d = unf_ev | (unf_q & ~flag_clr);
    assign ovf_d = ovf_ev | (ovf_q & ~flag_clr);

    // An event in the same cycle as a clear keeps its bit set.
    assign irq_stat_d = {ovf_ev, unf_ev} | (irq_stat_q & ~(wr_irq_clr ? wbyte : RST_REG));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chan_prev_q <= RST_REG[NFLG-1:0];
            unf_q <= RST_REG[NFLG-1:0];
            ovf_q <= RST_REG[NFLG-1:0];
            irq_stat_q <= RST_REG;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            chan_prev_q <= chan_q;
            unf_q <= unf_d;
            ovf_q <= ovf_d;
            irq_stat_q <= irq_stat_d;
            irq <= |(irq_stat_d & irq_en_q);
        end
    end
endmodule

// ### dv/scr_regs_asserts.sv
// Concurrent checks on the register bus and PLL pins of the serial channel block.
module scr_regs_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [scr_pkg::ADDR_W-1:0] paddr,
    input wire logic [scr_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [scr_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pll_lock,
    input wire logic pll_enable
);
    import scr_pkg::*;
    logic [7:0] pll_q;
    logic [7:0] pll_d;
    wire logic acc = psel && penable && pready;
    wire logic rd = acc && !pwrite;
    wire logic at_pll = paddr == {IDX_PLL, 2'b00};
    wire logic at_under = paddr == {IDX_UNDER, 2'b00};
    wire logic at_over = paddr == {IDX_OVER, 2'b00};
    wire logic wr_pll = ce && acc && pwrite && pstrb[0] && at_pll;
    assign pll_d = wr_pll ? pwdata[7:0] : pll_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pll_q <= RST_REG;
        else
            pll_q <= pll_d;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_first_access;
        psel && penable;
    endsequence
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    a_one_wait: assert property (s_setup ##1 s_first_access |-> !pready ##1 pready)
        else $error("access did not take exactly one wait state");
    a_unmapped_error: assert property (acc && paddr == 8'h04 |-> pslverr)
        else $error("unmapped access without error");
    a_pll_pin_follows: assert property (wr_pll |-> ##2 pll_enable == pll_q[PLL_ON_BIT])
        else $error("PLL enable pin does not follow the written bit");
    a_lock_reads_one: assert property (pll_lock [*6] ##0 (rd && at_pll) |-> prdata[5])
        else $error("lock bit reads zero while locked");
    a_lock_reads_zero: assert property ((!pll_lock) [*6] ##0 (rd && at_pll) |-> !prdata[5])
        else $error("lock bit reads one while unlocked");
    a_reserved_bits: assert property (rd && at_pll |-> prdata[7:6] == 2'h0 &&
        prdata[4:3] == pll_q[4:3] && prdata[1:0] == pll_q[1:0])
        else $error("PLL control reserved bits read wrong");
    a_status_upper_zero: assert property (rd && (at_under || at_over) |-> prdata[31:4] == 28'h0)
        else $error("flag register upper bits not zero");
    a_under_map: assert property (rd && at_under |-> prdata[1:0] == 2'h0)
        else $error("underflow flag on a receive channel");
    a_over_map: assert property (rd && at_over |-> prdata[3:2] == 2'h0)
        else $error("overflow flag on a transmit channel");
endmodule
bind scr_regs_top scr_regs_asserts i_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pll_lock(pll_lock),
    .pll_enable(pll_enable));

// ### dv/scr_far_end.sv
// Behavioural model of the main board logic at the far end of the serial links.
module scr_far_end (
    input wire logic run,
    input wire logic [31:0] rx_pat,
    input wire logic tx_bit,
    input wire logic pll_enable,
    output logic link_clk,
    output logic [1:0] rx_sdata,
    output logic pll_lock,
    output logic [31:0] tx_cap,
    output int n_edge
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] sh = 32'h00000000;
    initial
    begin
        link_clk = 1'b0;
        pll_lock = 1'b0;
        tx_cap = 32'h00000000;
        n_edge = 0;
    end
    // The clock stands still while idle, so the first rising edge carries bit 31.
    always
    begin
        #100;
        link_clk = run ? ~link_clk : 1'b0;
    end
    always @(posedge run)
    begin
        sh = rx_pat;
        n_edge = 0;
    end
    always @(negedge link_clk)
        sh <= {sh[30:0], sh[31]};
    assign rx_sdata = {~sh[31], sh[31]};
    // The sender's bit lags the rising edge by up to half a period, so the next rising edge
    // is the safe place to take it.
    always @(posedge link_clk)
    begin
        tx_cap <= {tx_cap[30:0], tx_bit};
        n_edge <= n_edge + 1;
    end
    always @(pll_enable)
        pll_lock <= #1000 pll_enable;
endmodule

// ### dv/scr_regs_top_tb.sv
// Self-checking bench for the serial channel register block.
module scr_regs_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import scr_pkg::*;
    localparam logic [31:0] RXW = 32'h12345678;
    localparam logic [31:0] TXW = 32'hA5C30F96;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h00000000;
    logic [DATA_W-1:0] prdata;
    logic pready, pslverr, link_clk, pll_lock, pll_enable, irq;
    logic run = 1'b0;
    logic [NCH-1:0] rx_sdata, tx_sdata, tx_ready, rx_valid;
    logic [NCH-1:0] tx_valid = 2'h0;
    logic [NCH-1:0] rx_ready = 2'h0;
    logic [NCH-1:0][WORD_W-1:0] tx_word = '0;
    logic [NCH-1:0][WORD_W-1:0] rx_word;
    logic [31:0] cap;
    int n_edge;
    int n_errors = 0;
    int comparisons = 0;
    always #12.5 pclk = ~pclk;
    scr_regs_top i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
        .rx_sdata(rx_sdata), .tx_sdata(tx_sdata), .tx_valid(tx_valid), .tx_word(tx_word),
        .tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .pll_lock(pll_lock), .pll_enable(pll_enable), .irq(irq));
    scr_far_end i_far (.run(run), .rx_pat(RXW), .tx_bit(tx_sdata[1]), .pll_enable(pll_enable),
        .link_clk(link_clk), .rx_sdata(rx_sdata), .pll_lock(pll_lock), .tx_cap(cap),
        .n_edge(n_edge));
    function automatic logic [7:0] ba(input logic [5:0] idx);
        return {idx, 2'b00};
    endfunction
    function automatic logic [31:0] ordw(input logic [31:0] x, input logic bs, input logic ss,
                                         input logic lsb);
        logic [31:0] a;
        logic [31:0] b;
        a = ss ? {x[15:0], x[31:16]} : x;
        b = bs ? {a[23:16], a[31:24], a[7:0], a[15:8]} : a;
        return lsb ? {<<{b}} : b;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // The master holds every request signal until the edge at which pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 40);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, {31'h0, pready});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(n, x, r);
    endtask
    task automatic till(input int n);
        int k;
        k = 0;
        while (n_edge < n && k < 20000)
        begin
            @(posedge pclk);
            k++;
        end
        chk("link edges", n, n_edge);
    endtask
    task automatic t_reset;
        rc("order", ba(IDX_ORDER), 32'h0);
        rc("under", ba(IDX_UNDER), 32'h0);
        rc("over", ba(IDX_OVER), 32'h0);
        rc("pll", ba(IDX_PLL), 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test reset done");
    endtask
    task automatic t_pll;
        wr(ba(IDX_PLL), 32'hDB);
        rc("pll reserved", ba(IDX_PLL), 32'h1B);
        chk("pll_enable", 32'h0, {31'h0, pll_enable});
        wr(ba(IDX_PLL), 32'h04);
        rc("pll unlocked", ba(IDX_PLL), 32'h04);
        chk("pll_enable", 32'h1, {31'h0, pll_enable});
        repeat (80) @(posedge pclk);
        rc("pll locked", ba(IDX_PLL), 32'h24);
        wr(ba(IDX_PLL), 32'h00);
        repeat (80) @(posedge pclk);
        rc("pll off", ba(IDX_PLL), 32'h00);
        $display("test pll done");
    endtask
    task automatic t_ro;
        logic [31:0] r;
        logic e;
        wr(ba(IDX_UNDER), 32'hFF);
        wr(ba(IDX_OVER), 32'hFF);
        rc("under ro", ba(IDX_UNDER), 32'h0);
        rc("over ro", ba(IDX_OVER), 32'h0);
        apb(1'b0, 8'h04, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        $display("test read-only done");
    endtask
    // Channel 0 receives LSB first and channel 1 sends MSB first, both with both swaps on.
    task automatic t_link;
        int k;
        logic [31:0] tw;
        wr(ba(IDX_SWAP), 32'h09);
        wr(ba(IDX_ORDER), 32'h01);
        wr(ba(IDX_IRQ_EN), 32'h08);
        wr(ba(IDX_CHAN), 32'h09);
        tx_word[1] <= TXW;
        tx_valid[1] <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (tx_ready[1] !== 1'b1 && k < 40);
        tx_valid[1] <= 1'b0;
        chk("tx_ready", 32'h1, {31'h0, tx_ready[1]});
        run <= 1'b1;
        till(65);
        chk("tx word", ordw(TXW, 1'b1, 1'b1, 1'b0), cap);
        chk("rx_valid", 32'h1, {31'h0, rx_valid[0]});
        chk("rx word", ordw(RXW, 1'b1, 1'b1, 1'b1), rx_word[0]);
        rc("over set", ba(IDX_OVER), 32'h01);
        rc("under set", ba(IDX_UNDER), 32'h08);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(ba(IDX_IRQ_EN), 32'h00);
        repeat (3) @(posedge pclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        rx_ready[0] <= 1'b1;
        @(posedge pclk);
        rx_ready[0] <= 1'b0;
        till(97);
        tw = ordw(TXW, 1'b1, 1'b1, 1'b0);
        chk("repeat byte", {4{tw[7:0]}}, cap);
        chk("rx dropped", 32'h0, {31'h0, rx_valid[0]});
        chk("rx1 word", 32'h0, rx_word[1]);
        chk("idle ch", 32'h0, {29'h0, tx_ready[0], rx_valid[1], tx_sdata[0]});
        run <= 1'b0;
        repeat (20) @(posedge pclk);
        wr(ba(IDX_IRQ_CLR), 32'h08);
        wr(ba(IDX_IRQ_EN), 32'h10);
        repeat (3) @(posedge pclk);
        chk("irq overflow", 32'h1, {31'h0, irq});
        wr(ba(IDX_IRQ_CLR), 32'h10);
        repeat (3) @(posedge pclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(ba(IDX_CHAN), 32'h00);
        rc("under held", ba(IDX_UNDER), 32'h08);
        wr(ba(IDX_CHAN), 32'h08);
        rc("under clear", ba(IDX_UNDER), 32'h0);
        rc("over kept", ba(IDX_OVER), 32'h01);
        wr(ba(IDX_CMD), 32'h01);
        rc("over clear", ba(IDX_OVER), 32'h0);
        wr(ba(IDX_CHAN), 32'h00);
        $display("test link done");
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_pll();
        t_ro();
        t_link();
        conclude();
    end
    initial
    begin
        #300us;
        n_errors++;
        $display("Error watchdog expected finish seen timeout");
        conclude();
    end
endmodule
